// *** bench/backup_supply_mode_control_test.sv ***
// self-checking testbench for the backup supply mode control
module backup_supply_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, sel_load, backup_bus_inhibit_sel, supply_switch_sel;
  logic backup_below_min, main_at_zero, backup_at_zero, acked;
  logic on_backup, low_voltage_reset_n, bus_enable, nvm_read_enable;
  logic nvm_write_enable, clock_or_alarm_enable;
  logic [1:0] mode;
  logic [3:0] cmp;
  logic [31:0] seed = 32'hbbb4635e;
  int n_mismatch = 0;
  int num_checks = 0;

  bsm_mode_ctrl bsm_mode_ctrl_inst (.mclk, .rst_n, .sel_load,
    .backup_bus_inhibit_sel, .supply_switch_sel, .main_below_trip(cmp[3]),
    .main_below_reset(cmp[2]), .main_below_backup(cmp[1]),
    .backup_below_reset(cmp[0]), .backup_below_min, .main_at_zero,
    .backup_at_zero, .on_backup, .low_voltage_reset_n, .bus_enable,
    .nvm_read_enable, .nvm_write_enable, .clock_or_alarm_enable, .mode);
  bsm_host_model bsm_host_model_inst (.mclk, .try_access(1'b1), .bus_enable,
    .acked);

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // {on_backup, bus answered, read, write, alarm} for a settled input set
  function automatic logic [4:0] expect_gates(logic [1:0] m, logic [3:0] c);
    logic ob, bus;
    ob = m[0] ? (c[1] & c[3]) : c[3];
    if (c[2]) bus = 1'b0;
    else if (ob) bus = (m == 2'b01) & !c[0];
    else if (m == 2'b11) bus = !c[1];
    else bus = 1'b1;
    // mode B refuses writes whenever backup beats main, on or off backup
    return {ob, bus, (m == 2'b01) | (!ob & !c[2]),
      !c[2] & ((m == 2'b01) ? !c[1] : !ob),
      !(ob & !m[0])};
  endfunction

  task automatic cmp_vec(string what, logic [4:0] got, logic [4:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // below reset implies below trip on a real supply
  task automatic apply(logic [1:0] m, logic [3:0] c);
    logic [4:0] e;
    logic [4:0] g;
    c[3] = c[3] | c[2];
    e = expect_gates(m, c);
    @(posedge mclk);
    sel_load <= 1'b1;
    {backup_bus_inhibit_sel, supply_switch_sel} <= m;
    cmp <= c;
    @(posedge mclk);
    sel_load <= 1'b0;
    repeat (7) @(posedge mclk);
    #1 g = {on_backup, acked, nvm_read_enable, nvm_write_enable,
      clock_or_alarm_enable};
    cmp_vec("supply", {4'h0, g[4]}, {4'h0, e[4]});
    cmp_vec("bus", {4'h0, g[3]}, {4'h0, e[3]});
    cmp_vec("nvm", {3'h0, g[2:1]}, {3'h0, e[2:1]});
    cmp_vec("alarm", {4'h0, g[0]}, {4'h0, e[0]});
    cmp_vec("reset", {4'h0, low_voltage_reset_n}, {4'h0, !c[2]});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    logic [31:0] r;
    rst_n = 1'b0;
    sel_load = 1'b0;
    {backup_bus_inhibit_sel, supply_switch_sel} = 2'b00;
    cmp = 4'h0;
    {backup_below_min, main_at_zero, backup_at_zero} = 3'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1 cmp_vec("mode", {3'h0, mode}, 5'h01);
    for (int i = 0; i < 64; i++) apply(i[5:4], i[3:0]);
    repeat (40)
    begin
      r = xorshift();
      apply(r[5:4], r[3:0]);
    end
    // back to back loads, the last one wins
    @(posedge mclk);
    sel_load <= 1'b1;
    {backup_bus_inhibit_sel, supply_switch_sel} <= 2'b11;
    @(posedge mclk);
    {backup_bus_inhibit_sel, supply_switch_sel} <= 2'b00;
    @(posedge mclk);
    sel_load <= 1'b0;
    #1 cmp_vec("mode", {3'h0, mode}, 5'h00);
    // weak backup while main cycles through zero
    cmp <= 4'he;
    {backup_below_min, main_at_zero} <= 2'b11;
    repeat (6) @(posedge mclk);
    main_at_zero <= 1'b0;
    cmp <= 4'h0;
    repeat (8) @(posedge mclk);
    #1 cmp_vec("lk", {3'h0, low_voltage_reset_n, bus_enable}, 5'h00);
    {backup_below_min, main_at_zero, backup_at_zero} <= 3'b011;
    repeat (6) @(posedge mclk);
    {main_at_zero, backup_at_zero} <= 2'b00;
    repeat (8) @(posedge mclk);
    #1 cmp_vec("lk", {3'h0, low_voltage_reset_n, bus_enable}, 5'h03);
    conclude();
  end

  // whole run needs about 970 cycles
  initial
  begin
    #80000;
    n_mismatch++;
    conclude();
  end
endmodule // backup_supply_mode_control_test

// *** bench/bsm_host_model.sv ***
// host processor model on the serial bus side
module bsm_host_model
(
  // clock
  input wire logic mclk,
  // bus handshake
  input wire logic try_access,
  input wire logic bus_enable,
  output logic acked
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-ups go to the backup supply, so on backup power an answer
  // is only seen while the device keeps its bus enabled
  always_ff @(posedge mclk)
  begin
    acked <= try_access & bus_enable;
  end
endmodule // bsm_host_model

// *** bench/bsm_mode_ctrl_assertions.sv ***
// port checker for the backup supply mode control
module bsm_mode_ctrl_chk
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // inputs
  input wire logic sel_load,
  input wire logic backup_bus_inhibit_sel,
  input wire logic supply_switch_sel,
  input wire logic main_below_trip,
  input wire logic main_below_reset,
  input wire logic main_below_backup,
  input wire logic backup_below_min,
  input wire logic main_at_zero,
  // outputs
  input wire logic on_backup,
  input wire logic bus_enable,
  input wire logic nvm_read_enable,
  input wire logic nvm_write_enable,
  input wire logic clock_or_alarm_enable,
  input wire logic [1:0] mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lk_q;
  logic [1:0] mode_q;
  logic ms;
  // lockup may change supply state, so those checks stand aside once armed
  always_ff @(posedge mclk)
  begin
    mode_q <= mode;
    lk_q <= rst_n & (lk_q | (backup_below_min & main_at_zero));
  end
  assign ms = (mode == mode_q) & !lk_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_mode_load: assert property (
    sel_load |=> mode[1] == $past(backup_bus_inhibit_sel)
    && mode[0] == $past(supply_switch_sel))
    else $error("mode not loaded");
  chk_mode_hold: assert property (
    !sel_load |=> $stable(mode)) else $error("mode changed without load");
  chk_default_mode: assert property (
    $rose(rst_n) |-> mode == 2'b01) else $error("mode after reset");
  chk_bus_reset_off: assert property (
    (main_below_reset && ms)[*5] |-> !bus_enable)
    else $error("bus on below reset");
  chk_std_switch: assert property (
    (main_below_trip && !mode[0] && ms)[*5] |-> on_backup)
    else $error("no standard switchover");
  chk_legacy_switch: assert property (
    (main_below_backup && main_below_trip && mode[0] && ms)[*5]
    |-> on_backup) else $error("no legacy switchover");
  chk_backup_quiet: assert property (
    on_backup && mode != 2'b01 && ms
    |-> !bus_enable && !nvm_read_enable && !nvm_write_enable)
    else $error("access on backup");
  chk_std_alarm: assert property (
    on_backup && !mode[0] && ms |-> !clock_or_alarm_enable)
    else $error("alarm on backup");
  chk_d_bus: assert property (
    (main_below_backup && mode == 2'b11 && ms)[*5] |-> !bus_enable)
    else $error("mode d bus below backup");
  chk_b_write: assert property (
    (main_below_backup && mode == 2'b01 && ms)[*5] |-> !nvm_write_enable)
    else $error("write with backup above main");
  cov_b_bus: cover property (on_backup && mode == 2'b01 && bus_enable);
  cov_a_backup: cover property (on_backup && mode == 2'b00);
  cov_load_twice: cover property (sel_load ##1 sel_load);
endmodule // bsm_mode_ctrl_chk

bind bsm_mode_ctrl bsm_mode_ctrl_chk bsm_mode_ctrl_chk_inst (.mclk, .rst_n,
  .sel_load, .backup_bus_inhibit_sel, .supply_switch_sel, .main_below_trip,
  .main_below_reset, .main_below_backup, .backup_below_min, .main_at_zero,
  .on_backup, .bus_enable, .nvm_read_enable, .nvm_write_enable,
  .clock_or_alarm_enable, .mode);

// *** design/bsm_mode_ctrl.sv ***
// backup supply mode control: supply selection and access gating
//
// How it works
// [RULE1] before the select bits are loaded the block runs in mode B.
// [RULE2] main below the reset threshold always blocks the serial bus.
// [RULE3] the two select bits decode into modes A, B, C and D.
// [RULE4] modes A and C switch to backup when main is below trip.
// [RULE5] on backup in modes A and C timekeeping is disabled along with bus and memory.
// [RULE6] modes B and D run from backup when it beats main and trip.
// [RULE7] mode B keeps alarms and bus alive on backup power.
// [RULE8] mode B bus on backup needs backup and main above reset.
// [RULE9] mode B allows memory on backup but blocks writes when backup>main.
// [RULE10] modes A, C and D refuse bus and memory while on backup.
// [RULE11] mode A answers the bus down to the main trip threshold.
// [RULE12] mode D answers only while main beats both reset and backup.
// [RULE13] backup below minimum plus main cycling to 0V locks reset low.
// [RULE14] comparators are synchronised and gating recomputed each cycle.
module bsm_mode_ctrl
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // mode selection from the configuration store
  input wire logic sel_load,
  input wire logic backup_bus_inhibit_sel,
  input wire logic supply_switch_sel,
  // comparator levels from the analog front end
  input wire logic main_below_trip,
  input wire logic main_below_reset,
  input wire logic main_below_backup,
  input wire logic backup_below_reset,
  input wire logic backup_below_min,
  input wire logic main_at_zero,
  input wire logic backup_at_zero,
  // supply and gating outputs
  output logic on_backup,
  output logic low_voltage_reset_n,
  output logic bus_enable,
  output logic nvm_read_enable,
  output logic nvm_write_enable,
  output logic clock_or_alarm_enable,
  output logic [1:0] mode
);

  // ----------------------------------------------------------------
  // comparator synchronisers
  // ----------------------------------------------------------------
  localparam int NCMP = 7;
  logic [NCMP-1:0] cmp_raw;
  logic [NCMP-1:0] cmp_s;

  assign cmp_raw = {backup_at_zero, main_at_zero, backup_below_min,
                    backup_below_reset, main_below_backup,
                    main_below_reset, main_below_trip};

  genvar gi;
  generate
    for (gi = 0; gi < NCMP; gi++)
    begin : g_sync
      bsm_sync u_sync // RULE14
      (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(cmp_raw[gi]),
        .sync_out(cmp_s[gi])
      );
    end
  endgenerate

  logic m_trip;
  logic m_rst;
  logic m_bak;
  logic b_rst;
  logic b_min;
  logic m_zero;
  logic b_zero;
  assign m_trip = cmp_s[0];
  assign m_rst = cmp_s[1];
  assign m_bak = cmp_s[2];
  assign b_rst = cmp_s[3];
  assign b_min = cmp_s[4];
  assign m_zero = cmp_s[5];
  assign b_zero = cmp_s[6];

  // ----------------------------------------------------------------
  // mode select register
  // ----------------------------------------------------------------
  logic inhibit_q;
  logic inhibit_d;
  logic switch_q;
  logic switch_d;

  always_comb
  begin
    inhibit_d = inhibit_q;
    switch_d = switch_q;
    if (sel_load)
    begin
      inhibit_d = backup_bus_inhibit_sel;
      switch_d = supply_switch_sel;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      inhibit_q <= bsm_pkg::BSM_BUS_INHIBIT_RST; // RULE1
      switch_q <= bsm_pkg::BSM_SWITCH_SEL_RST; // RULE1
    end
    else
    begin
      inhibit_q <= inhibit_d;
      switch_q <= switch_d;
    end
  end

  bsm_pkg::bsm_mode_t mode_sel;
  assign mode_sel = bsm_pkg::bsm_mode_t'({inhibit_q, switch_q}); // RULE3
  logic legacy;
  assign legacy = switch_q;

  // ----------------------------------------------------------------
  // supply selection and lockup state
  // ----------------------------------------------------------------
  bsm_pkg::bsm_supply_t sup_q;
  bsm_pkg::bsm_supply_t sup_d;
  logic want_backup;
  logic armed_q;
  logic armed_d;

  always_comb
  begin
    // standard switches at trip, legacy when backup beats main and trip
    if (legacy)
      want_backup = m_bak && m_trip; // RULE6
    else
      want_backup = m_trip; // RULE4
  end

  always_comb
  begin
    sup_d = sup_q;
    // lockup arms once backup sags below minimum while main is dead
    armed_d = armed_q | (b_min & m_zero); // RULE13
    case (sup_q)
      bsm_pkg::BSM_SUP_MAIN:
      begin
        if (want_backup)
          sup_d = bsm_pkg::BSM_SUP_BACKUP;
      end
      bsm_pkg::BSM_SUP_BACKUP:
      begin
        if (armed_d && !m_zero)
          sup_d = bsm_pkg::BSM_SUP_LOCKED; // RULE13
        else if (!want_backup)
          sup_d = bsm_pkg::BSM_SUP_MAIN;
      end
      bsm_pkg::BSM_SUP_LOCKED:
      begin
        // only both supplies at zero together clear it
        if (m_zero && b_zero)
        begin
          sup_d = bsm_pkg::BSM_SUP_MAIN; // RULE13
          armed_d = 1'b0;
        end
      end
      default:
        sup_d = bsm_pkg::BSM_SUP_MAIN;
    endcase
    if (sup_q == bsm_pkg::BSM_SUP_MAIN && armed_d && !m_zero)
      sup_d = bsm_pkg::BSM_SUP_LOCKED; // RULE13
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sup_q <= bsm_pkg::BSM_SUP_MAIN;
      armed_q <= 1'b0;
    end
    else
    begin
      sup_q <= sup_d;
      armed_q <= armed_d;
    end
  end

  // ----------------------------------------------------------------
  // access gating, recomputed every cycle
  // ----------------------------------------------------------------
  logic bus_d;
  logic bus_q;
  logic rd_d;
  logic rd_q;
  logic wr_d;
  logic wr_q;
  logic alarm_d;
  logic alarm_q;
  logic bak_d;
  logic bak_q;
  logic lvr_d;
  logic lvr_q;
  logic locked;
  logic backup_now;

  assign locked = (sup_q == bsm_pkg::BSM_SUP_LOCKED);
  assign backup_now = (sup_q != bsm_pkg::BSM_SUP_MAIN);

  always_comb
  begin
    bak_d = backup_now;
    lvr_d = !(m_rst || locked); // RULE13
    bus_d = !backup_now; // RULE10
    rd_d = !backup_now; // RULE10
    wr_d = !backup_now; // RULE10
    alarm_d = 1'b1;
    case (mode_sel)
      bsm_pkg::BSM_MODE_A:
      begin
        bus_d = !backup_now; // RULE11
        alarm_d = !backup_now; // RULE5
      end
      bsm_pkg::BSM_MODE_B:
      begin
        // backup power keeps the bus only above both reset levels
        bus_d = !backup_now || !b_rst; // RULE8
        rd_d = 1'b1; // RULE9
        wr_d = !m_bak; // RULE9
        alarm_d = 1'b1; // RULE7
      end
      bsm_pkg::BSM_MODE_C:
      begin
        alarm_d = !backup_now; // RULE5
      end
      bsm_pkg::BSM_MODE_D:
      begin
        // main must beat backup as well as the reset threshold
        bus_d = !backup_now && !m_bak; // RULE12
        alarm_d = 1'b1; // RULE7
      end
      default:
      begin
        bus_d = 1'b0;
      end
    endcase
    if (m_rst || locked)
    begin
      // low main kills the bus whatever the mode says
      bus_d = 1'b0; // RULE2
      rd_d = rd_d && mode_sel == bsm_pkg::BSM_MODE_B && !locked;
      wr_d = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bak_q <= 1'b0;
      lvr_q <= 1'b0;
      bus_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      alarm_q <= 1'b0;
    end
    else
    begin
      bak_q <= bak_d;
      lvr_q <= lvr_d;
      bus_q <= bus_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      alarm_q <= alarm_d;
    end
  end

  assign on_backup = bak_q;
  assign low_voltage_reset_n = lvr_q;
  assign bus_enable = bus_q;
  assign nvm_read_enable = rd_q;
  assign nvm_write_enable = wr_q;
  assign clock_or_alarm_enable = alarm_q;
  assign mode = {inhibit_q, switch_q};

endmodule // bsm_mode_ctrl

// *** design/bsm_sync.sv ***
// two flip-flop synchroniser for the comparator inputs
module bsm_sync
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // data
  input wire logic async_in,
  output logic sync_out
);

  logic [1:0] stage_q;
  logic [1:0] stage_d;

  always_comb
  begin
    stage_d = {stage_q[0], async_in};
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      stage_q <= bsm_pkg::BSM_SYNC_RST;
    else
      stage_q <= stage_d;
  end

  // only the second stage is visible
  assign sync_out = stage_q[1];

endmodule // bsm_sync

// *** shared/bsm_pkg.sv ***
// constants and types for the backup supply mode control block
package bsm_pkg;

  // ----------------------------------------------------------------
  // mode select encoding {backup_bus_inhibit_sel, supply_switch_sel}
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    BSM_MODE_A = 2'b00,
    BSM_MODE_B = 2'b01,
    BSM_MODE_C = 2'b10,
    BSM_MODE_D = 2'b11
  } bsm_mode_t;

  // ----------------------------------------------------------------
  // supply selection state
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    BSM_SUP_MAIN = 2'b00,
    BSM_SUP_BACKUP = 2'b01,
    BSM_SUP_LOCKED = 2'b10
  } bsm_supply_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic BSM_BUS_INHIBIT_RST = 1'b0;
  localparam logic BSM_SWITCH_SEL_RST = 1'b1;
  localparam logic [1:0] BSM_SYNC_RST = 2'h0;

endpackage
